// ==== include/mlc_pkg.sv ====
/*
 * Package for the motor loop control core: register map, field positions,
 * reset values, operating modes and timing constants.
 * Assumes a 50 MHz control clock and a 32-bit Avalon-MM register port.
 */
package mlc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned MLC_CLK_HZ = 50_000_000;
    localparam int unsigned MLC_MS_PER_S = 1000;
    localparam int unsigned MLC_CYC_PER_MS = MLC_CLK_HZ / MLC_MS_PER_S;
    localparam int unsigned MLC_CTRL_PERIOD_US = 20;
    localparam int unsigned MLC_US_PER_S = 1_000_000;
    localparam int unsigned MLC_CTRL_PERIOD_CYC =
        MLC_CLK_HZ / MLC_US_PER_S * MLC_CTRL_PERIOD_US;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] MLC_REG_SUBMODE = 8'h00;
    localparam logic [7:0] MLC_REG_MODE = 8'h04;
    localparam logic [7:0] MLC_REG_RATED_MA = 8'h08;
    localparam logic [7:0] MLC_REG_MAXCUR = 8'h0C;
    localparam logic [7:0] MLC_REG_IDLE_MS = 8'h10;
    localparam logic [7:0] MLC_REG_RED_VAL = 8'h14;
    localparam logic [7:0] MLC_REG_LEGACY = 8'h18;
    localparam logic [7:0] MLC_REG_KP_BASE = 8'h20;
    localparam logic [7:0] MLC_REG_TN_BASE = 8'h30;
    localparam logic [7:0] MLC_REG_EMAX_BASE = 8'h40;
    localparam logic [7:0] MLC_REG_YMAX_BASE = 8'h50;
    localparam logic [7:0] MLC_REG_STATUS = 8'h60;
    localparam logic [7:0] MLC_REG_CUR_OUT = 8'h64;
    localparam logic [7:0] MLC_REG_CUR_LIMIT = 8'h68;

    ////////////////////////////////////////////////////////////////////////
    // Submode bit positions and reset values
    localparam int unsigned MLC_BIT_LOOP_SELECT = 0;
    localparam int unsigned MLC_BIT_VEL_POS = 1;
    localparam int unsigned MLC_BIT_STANDSTILL_CUT = 3;
    localparam int unsigned MLC_BIT_REAL_TORQUE = 5;
    localparam logic [15:0] MLC_MAXCUR_CEIL = 16'h03E8;
    localparam logic [15:0] MLC_MAXCUR_RST = 16'h03E8;
    localparam logic [15:0] MLC_GAIN_UNITY = 16'h03E8;
    localparam logic [1:0] MLC_LEGACY_RST = 2'h3;

    // Operating modes, one code per mode
    typedef enum logic [3:0] {
        MLC_MODE_PP = 4'h1,
        MLC_MODE_VEL = 4'h2,
        MLC_MODE_PV = 4'h3,
        MLC_MODE_TQ = 4'h4,
        MLC_MODE_HOME = 4'h6,
        MLC_MODE_IP = 4'h7,
        MLC_MODE_CSP = 4'h8,
        MLC_MODE_CSV = 4'h9,
        MLC_MODE_CST = 4'hA,
        MLC_MODE_CLKDIR = 4'hF
    } mlc_mode_t;

    // Parameter set of one PI stage
    typedef struct packed {
        logic [15:0] kp;
        logic [15:0] tn;
        logic [15:0] emax;
        logic [15:0] ymax;
    } mlc_pi_cfg_t;

    // Avalon-MM slave request
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } mlc_avm_req_t;

endpackage

// ==== rtl/mlc_pi_stage.sv ====
/*
 * One proportional-integral stage with deviation scaling and saturation.
 * Assumes the caller strobes step_in once per control period.
 */
module mlc_pi_stage
    import mlc_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Control
    input wire logic step_in,
    input wire logic enable_in,
    input wire mlc_pi_cfg_t cfg_in,
    input wire logic signed [W-1:0] setpoint_in,
    input wire logic signed [W-1:0] actual_in,
    // Result
    output logic signed [W-1:0] y_out
);

    // Deviation scaled so emax maps to ymax at unity gain
    logic signed [W:0] err;
    logic signed [2*W+18:0] p_term;
    logic signed [2*W+18:0] i_step;
    logic signed [2*W+18:0] acc_q;
    logic signed [2*W+18:0] acc_d;
    logic signed [2*W+18:0] sum;
    logic signed [W:0] ymax_s;
    logic signed [W-1:0] y_d;
    logic signed [W-1:0] y_q;
    wire [W+1:0] emax_nz = (cfg_in.emax == '0) ? (W+2)'(1) : {2'b00, cfg_in.emax};

    assign err = setpoint_in - actual_in;
    assign ymax_s = $signed({1'b0, cfg_in.ymax});
    assign p_term = ((2*W+19)'(err) * $signed({1'b0, cfg_in.ymax}) * $signed({1'b0, cfg_in.kp}))
        / $signed({1'b0, MLC_GAIN_UNITY}) / $signed({1'b0, emax_nz});
    // Zero reset time disables the integrator; short reset time grows it faster
    assign i_step = (cfg_in.tn == '0) ? '0 : p_term / $signed({1'b0, cfg_in.tn});
    assign acc_d = (!enable_in || cfg_in.tn == '0) ? '0 : acc_q + i_step;
    assign sum = p_term + acc_d;
    // Saturate; the integrator is clamped too, avoiding windup
    assign y_d = !enable_in ? '0 :
        (sum > (2*W+19)'(ymax_s)) ? W'(ymax_s) :
        (sum < -(2*W+19)'(ymax_s)) ? W'(-ymax_s) : W'(sum);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_q <= '0;
            y_q <= '0;
        end else if (step_in) begin
            acc_q <= (acc_d > (2*W+19)'(ymax_s)) ? (2*W+19)'(ymax_s) :
                (acc_d < -(2*W+19)'(ymax_s)) ? -(2*W+19)'(ymax_s) : acc_d;
            y_q <= y_d;
        end
    end

    assign y_out = y_q;

    // Output never leaves the ceiling
    a_out_saturated: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (y_q <= $signed({1'b0, cfg_in.ymax}) && y_q >= -$signed({1'b0, cfg_in.ymax})))
        else $error("pi output beyond ceiling");

    // Zero reset time leaves no integral memory
    a_tn_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (step_in && cfg_in.tn == '0) |=> (acc_q == '0))
        else $error("integrator active at zero reset time");

endmodule

// ==== rtl/mlc_core.sv ====
/*
 * Motor loop control core: open/closed loop select, open-loop current
 * clamp and standstill reduction, and the three-stage PI cascade.
 * Assumes a 50 MHz clock, asynchronous active-low reset and a 32-bit
 * Avalon-MM master that holds its request until waitrequest is low.
 */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
module mlc_core
    import mlc_pkg::*;
#(
    parameter int W = 16,
    parameter int unsigned CTRL_PERIOD_CYC = MLC_CTRL_PERIOD_CYC,
    parameter int unsigned CYC_PER_MS = MLC_CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Setpoints and feedback
    input wire logic signed [W-1:0] pos_set_in,
    input wire logic signed [W-1:0] pos_act_in,
    input wire logic signed [W-1:0] vel_set_in,
    input wire logic signed [W-1:0] vel_act_in,
    input wire logic signed [W-1:0] cur_act_in,
    // Drive outputs
    output logic signed [W-1:0] pwm_duty_out,
    output logic [15:0] cur_limit_out,
    output logic closed_loop_out,
    output logic reducing_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] submode_q;
    logic [3:0] mode_q;
    logic [15:0] rated_ma_q;
    logic [15:0] maxcur_q;
    logic [15:0] idle_ms_q;
    logic [15:0] red_val_q;
    logic [1:0] legacy_q;
    logic [1:0] legacy_seen_q;
    mlc_pi_cfg_t cfg_q [3];
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Bus decode: one wait state, then the answer
    wire wr_go = avs_write_in && ack_q;
    wire access = avs_read_in || avs_write_in;
    wire [1:0] stage_sel = avs_address_in[3:2];
    wire [7:0] grp = {avs_address_in[7:4], 4'h0};
    assign avs_waitrequest_out = access && !ack_q;

    // Stage enables
    wire closed_loop = submode_q[MLC_BIT_LOOP_SELECT];
    wire is_vel_mode = (mode_q == MLC_MODE_VEL) || (mode_q == MLC_MODE_PV) ||
        (mode_q == MLC_MODE_CSV);
    wire is_pos_mode = (mode_q == MLC_MODE_PP) || (mode_q == MLC_MODE_HOME) ||
        (mode_q == MLC_MODE_IP) || (mode_q == MLC_MODE_CSP) ||
        (mode_q == MLC_MODE_CLKDIR);
    wire is_torque = (mode_q == MLC_MODE_TQ) || (mode_q == MLC_MODE_CST);
    wire pos_en = closed_loop && (is_pos_mode ||
        (is_vel_mode && submode_q[MLC_BIT_VEL_POS]));
    wire vel_en = closed_loop && !(is_torque && submode_q[MLC_BIT_REAL_TORQUE]);
    wire cur_en = 1'b1;

    // Clamped maximum current and its value in milliamperes
    wire [15:0] maxcur_eff = (maxcur_q > MLC_MAXCUR_CEIL) ? MLC_MAXCUR_CEIL : maxcur_q;
    wire [31:0] maxcur_ma32 = (32'(rated_ma_q) * 32'(maxcur_eff)) / 32'(MLC_MAXCUR_CEIL);
    wire [15:0] maxcur_ma = maxcur_ma32[15:0];

    // Readback mux
    always_comb begin
        rdata_d = '0;
        if (avs_address_in == MLC_REG_SUBMODE) begin
            rdata_d = 32'(submode_q);
        end else if (avs_address_in == MLC_REG_MODE) begin
            rdata_d = 32'(mode_q);
        end else if (avs_address_in == MLC_REG_RATED_MA) begin
            rdata_d = 32'(rated_ma_q);
        end else if (avs_address_in == MLC_REG_MAXCUR) begin
            rdata_d = 32'(maxcur_q);
        end else if (avs_address_in == MLC_REG_IDLE_MS) begin
            rdata_d = 32'(idle_ms_q);
        end else if (avs_address_in == MLC_REG_RED_VAL) begin
            rdata_d = 32'(red_val_q);
        end else if (avs_address_in == MLC_REG_LEGACY) begin
            rdata_d = 32'(legacy_q);
        end else if (grp == MLC_REG_KP_BASE && stage_sel != 2'h3) begin
            rdata_d = 32'(cfg_q[stage_sel].kp);
        end else if (grp == MLC_REG_TN_BASE && stage_sel != 2'h3) begin
            rdata_d = 32'(cfg_q[stage_sel].tn);
        end else if (grp == MLC_REG_EMAX_BASE && stage_sel != 2'h3) begin
            rdata_d = 32'(cfg_q[stage_sel].emax);
        end else if (grp == MLC_REG_YMAX_BASE && stage_sel != 2'h3) begin
            rdata_d = 32'(cfg_q[stage_sel].ymax);
        end else if (avs_address_in == MLC_REG_STATUS) begin
            rdata_d = {26'h000_0000, legacy_seen_q, reducing_out, vel_en, pos_en, closed_loop};
        end else if (avs_address_in == MLC_REG_CUR_OUT) begin
            rdata_d = 32'($unsigned(pwm_duty_out)); // Upper bits read zero
        end else if (avs_address_in == MLC_REG_CUR_LIMIT) begin
            rdata_d = 32'(cur_limit_out);
        end
    end

    // Bus handshake; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= access && !ack_q;
            rdata_q <= rdata_d;
        end
    end
    assign avs_readdata_out = rdata_q;

    // Scalar configuration registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            submode_q <= '0;
            mode_q <= MLC_MODE_PP;
            rated_ma_q <= '0;
            maxcur_q <= MLC_MAXCUR_RST;
            idle_ms_q <= '0;
            red_val_q <= '0;
            legacy_q <= MLC_LEGACY_RST;
        end else if (wr_go) begin
            if (avs_address_in == MLC_REG_SUBMODE) submode_q <= avs_writedata_in[7:0];
            if (avs_address_in == MLC_REG_MODE) mode_q <= avs_writedata_in[3:0];
            if (avs_address_in == MLC_REG_RATED_MA) rated_ma_q <= avs_writedata_in[15:0];
            if (avs_address_in == MLC_REG_MAXCUR) maxcur_q <= avs_writedata_in[15:0];
            if (avs_address_in == MLC_REG_IDLE_MS) idle_ms_q <= avs_writedata_in[15:0];
            if (avs_address_in == MLC_REG_RED_VAL) red_val_q <= avs_writedata_in[15:0];
            if (avs_address_in == MLC_REG_LEGACY) legacy_q <= avs_writedata_in[1:0];
        end
    end

    // Legacy selector is captured once, on the first clock after reset release; reset has
    // just loaded legacy_q with MLC_LEGACY_RST, so the live set always holds that value.
    logic boot_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boot_q <= 1'b1;
            legacy_seen_q <= MLC_LEGACY_RST;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) legacy_seen_q <= legacy_q;
        end
    end

    // Per-stage PI parameters; legacy gain is unity while legacy is live
    genvar gs;
    generate
        for (gs = 0; gs < 3; gs++) begin : g_cfg
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    cfg_q[gs] <= '{kp: MLC_GAIN_UNITY, tn: '0, emax: MLC_GAIN_UNITY,
                        ymax: MLC_GAIN_UNITY};
                end else if (wr_go && stage_sel == 2'(gs)) begin
                    if (grp == MLC_REG_KP_BASE) cfg_q[gs].kp <= avs_writedata_in[15:0];
                    if (grp == MLC_REG_TN_BASE) cfg_q[gs].tn <= avs_writedata_in[15:0];
                    if (grp == MLC_REG_EMAX_BASE) cfg_q[gs].emax <= avs_writedata_in[15:0];
                    if (grp == MLC_REG_YMAX_BASE) cfg_q[gs].ymax <= avs_writedata_in[15:0];
                end
            end
        end
    endgenerate

    // Effective configs: legacy mode runs plain P with unity gain
    mlc_pi_cfg_t cfg_eff [3];
    wire use_legacy = closed_loop ? legacy_seen_q[0] : legacy_seen_q[1];
    assign cfg_eff[0] = use_legacy ? '{kp: MLC_GAIN_UNITY, tn: '0, emax: cfg_q[0].emax,
        ymax: cfg_q[0].ymax} : cfg_q[0];
    assign cfg_eff[1] = use_legacy ? '{kp: MLC_GAIN_UNITY, tn: '0, emax: cfg_q[1].emax,
        ymax: maxcur_ma} : '{kp: cfg_q[1].kp, tn: cfg_q[1].tn, emax: cfg_q[1].emax,
        ymax: maxcur_ma};
    assign cfg_eff[2] = use_legacy ? '{kp: MLC_GAIN_UNITY, tn: '0, emax: cfg_q[2].emax,
        ymax: cfg_q[2].ymax} : cfg_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Control period tick
    localparam int TICK_W = $clog2(CTRL_PERIOD_CYC + 1);
    logic [TICK_W-1:0] tick_cnt_q;
    wire tick = (tick_cnt_q == '0);
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? TICK_W'(CTRL_PERIOD_CYC - 1) : tick_cnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cascade: position -> velocity -> current
    logic signed [W-1:0] pos_y;
    logic signed [W-1:0] vel_y;
    logic signed [W-1:0] cur_y;
    wire signed [W-1:0] vel_ref = pos_en ? pos_y : vel_set_in;
    wire signed [W-1:0] cur_ref = closed_loop ?
        (vel_en ? vel_y : $signed(cur_limit_out)) : $signed(cur_limit_out);

    mlc_pi_stage #(.W(W)) u_pos (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .step_in(tick),
        .enable_in(pos_en),
        .cfg_in(cfg_eff[0]),
        .setpoint_in(pos_set_in),
        .actual_in(pos_act_in),
        .y_out(pos_y)
    );
    mlc_pi_stage #(.W(W)) u_vel (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .step_in(tick),
        .enable_in(vel_en),
        .cfg_in(cfg_eff[1]),
        .setpoint_in(vel_ref),
        .actual_in(vel_act_in),
        .y_out(vel_y)
    );
    mlc_pi_stage #(.W(W)) u_cur (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .step_in(tick),
        .enable_in(cur_en),
        .cfg_in(cfg_eff[2]),
        .setpoint_in(cur_ref),
        .actual_in(cur_act_in),
        .y_out(cur_y)
    );
    assign pwm_duty_out = cur_y;

    ////////////////////////////////////////////////////////////////////////
    // Open-loop standstill reduction
    localparam int MS_W = $clog2(CYC_PER_MS + 1);
    logic [MS_W-1:0] ms_cnt_q;
    logic [15:0] idle_q;
    logic red_q;
    logic [15:0] limit_q;
    wire ms_tick = (ms_cnt_q == '0);
    wire still = (vel_set_in == '0);
    wire red_allowed = !closed_loop && submode_q[MLC_BIT_STANDSTILL_CUT];
    wire [15:0] limit_d = red_q ? red_val_q : maxcur_ma;

    // Idle timer restarts on any nonzero set value
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ms_cnt_q <= '0;
            idle_q <= '0;
            red_q <= 1'b0;
            limit_q <= '0;
        end else begin
            ms_cnt_q <= (ms_tick || !still) ? MS_W'(CYC_PER_MS - 1) : ms_cnt_q - 1'b1;
            if (!still || !red_allowed) begin
                idle_q <= '0;
                red_q <= 1'b0;
            end else if (ms_tick && idle_q < idle_ms_q) begin
                idle_q <= idle_q + 16'h0001;
            end else if (idle_q >= idle_ms_q) begin
                red_q <= 1'b1;
            end
            limit_q <= limit_d;
        end
    end
    assign cur_limit_out = limit_q;
    assign reducing_out = red_q;
    assign closed_loop_out = closed_loop;

    // Reduction only with cut enabled in open loop
    a_red_gated: assert property (@(posedge clk_in) disable iff (!resetn_in)
        red_q |-> $past(red_allowed))
        else $error("reduction without enable");
    // Limit never passes the rated current while not reducing
    a_limit_clamp: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!red_q && !$past(red_q)) |-> (limit_q <= rated_ma_q || $past(rated_ma_q) != rated_ma_q))
        else $error("limit above rated");
    // Current stage enabled always
    a_cur_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cur_en)
        else $error("current stage off");
    // Velocity stage off in real torque
    a_vel_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (is_torque && submode_q[MLC_BIT_REAL_TORQUE]) |-> !vel_en)
        else $error("velocity stage on in real torque");
    // Position stage follows mode
    a_pos_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (closed_loop && is_pos_mode) |-> pos_en)
        else $error("position stage off in position mode");
    // Loop output mirrors the select bit
    a_loop_sel: assert property (@(posedge clk_in) disable iff (!resetn_in)
        closed_loop_out == submode_q[MLC_BIT_LOOP_SELECT])
        else $error("loop select mismatch");
    // Reduced limit drives the output a cycle later
    a_red_value: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ($past(red_q) && red_q && $stable(red_val_q)) |-> (cur_limit_out == red_val_q))
        else $error("reduced limit wrong");
    // Ticks never fall on two consecutive cycles
    a_tick_gap: assert property (@(posedge clk_in) disable iff (!resetn_in)
        tick |=> !tick)
        else $error("control tick too frequent");
    // Answer comes one cycle after request
    a_bus_answer: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ($rose(access)) |-> avs_waitrequest_out)
        else $error("answer too early");

endmodule

// ==== test/mlc_host.sv ====
/*
 * Host-side model: Avalon-MM master that writes and reads configuration words.
 * Assumes the slave answers with waitrequest low and the bench calls its tasks.
 */
module mlc_host
    import mlc_pkg::*;
(
    // Bus clock
    input wire logic clk_in,
    // Slave answer
    input wire logic [31:0] readdata_in,
    input wire logic waitrequest_in,
    // Request
    output logic [7:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        address_out = 8'h00;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer; request held until the edge that sees waitrequest low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        q = 32'h0000_0000;
        @(posedge clk_in);
        address_out <= a;
        writedata_out <= d;
        read_out <= !wr;
        write_out <= wr;
        // Read data is taken at that same edge, then the request drops
        while (!ok && n < 50) begin
            @(posedge clk_in);
            ok = (waitrequest_in === 1'b0);
            if (ok) q = readdata_in;
            n++;
        end
        read_out <= 1'b0;
        write_out <= 1'b0;
    endtask
    // Rated current, maximum current and pole pairs are host duties
endmodule

// ==== test/mlc_core_bench.sv ====
/*
 * Bench for the motor loop control core: limits, loop select, reduction.
 * Assumes shortened timing parameters and the host model on the bus.
 */
module mlc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mlc_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] address;
    logic read, write, waitreq, closed_loop, reducing;
    logic [31:0] writedata, readdata, q;
    logic signed [15:0] pos_set = 16'sh0000, vel_set = 16'sh0000, pwm;
    logic [15:0] cur_limit;
    int mismatches = 0;
    int n_tests = 0;

    mlc_core #(.CTRL_PERIOD_CYC(4), .CYC_PER_MS(10)) DUT (.clk_in(clk_in),
        .resetn_in(resetn_in), .avs_address_in(address), .avs_read_in(read),
        .avs_write_in(write), .avs_writedata_in(writedata), .avs_readdata_out(readdata),
        .avs_waitrequest_out(waitreq), .pos_set_in(pos_set), .pos_act_in(16'sh0000),
        .vel_set_in(vel_set), .vel_act_in(16'sh0000), .cur_act_in(16'sh0000),
        .pwm_duty_out(pwm), .cur_limit_out(cur_limit), .closed_loop_out(closed_loop),
        .reducing_out(reducing));
    mlc_host host (.clk_in(clk_in), .readdata_in(readdata), .waitrequest_in(waitreq),
        .address_out(address), .read_out(read), .write_out(write),
        .writedata_out(writedata));

    ////////////////////////////////////////////////////////////////////////
    // Clock, checks and bus helpers
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ok;
        host.xfer(1'b1, a, d, q, ok);
        chk(ok, 1'b1);
        if (!ok) final_report();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic ok;
        host.xfer(1'b0, a, 32'h0000_0000, q, ok);
        chk(ok, 1'b1);
        if (!ok) final_report();
        chk(q, exp);
    endtask
    task automatic final_report();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic reset_values();
        rd_chk(MLC_REG_MAXCUR, 32'h0000_03E8);
        rd_chk(MLC_REG_LEGACY, 32'h0000_0003);
        rd_chk(MLC_REG_KP_BASE, 32'h0000_03E8);
        rd_chk(8'h2C, 32'h0000_0000); // Stage three is unmapped
        rd_chk(8'h7C, 32'h0000_0000);
    endtask
    task automatic open_loop_limit();
        wr(MLC_REG_SUBMODE, 32'h0000_0000);
        wr(MLC_REG_RATED_MA, 32'h0000_0320);
        wr(MLC_REG_MAXCUR, 32'h0000_05DC);
        repeat (4) @(posedge clk_in);
        chk(closed_loop, 1'b0);
        chk(cur_limit, 16'h0320);
        // Deviation 800 of limit 1000 at unity gain gives 800
        chk(pwm, 32'h0000_0320);
        wr(MLC_REG_MAXCUR, 32'h0000_01F4);
        rd_chk(MLC_REG_CUR_LIMIT, 32'h0000_0190);
    endtask
    task automatic standstill_cut();
        int n;
        wr(MLC_REG_IDLE_MS, 32'h0000_0002);
        wr(MLC_REG_RED_VAL, 32'h0000_0064);
        repeat (60) @(posedge clk_in);
        chk(reducing, 1'b0);
        vel_set <= 16'sh0010;
        wr(MLC_REG_SUBMODE, 32'h0000_0008);
        repeat (30) @(posedge clk_in);
        chk(reducing, 1'b0);
        vel_set <= 16'sh0000;
        n = 0;
        while (reducing !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 200) final_report();
        // Two idle milliseconds of ten cycles, plus a few cycles of latency
        chk(n >= 20 && n <= 25, 1'b1);
        repeat (2) @(posedge clk_in);
        chk(cur_limit, 16'h0064);
        vel_set <= 16'sh0010;
        repeat (4) @(posedge clk_in);
        chk(reducing, 1'b0);
    endtask
    task automatic stage_enables();
        // Status low bits: closed, position on, velocity on; legacy bits stay set
        wr(MLC_REG_SUBMODE, 32'h0000_0001);
        wr(MLC_REG_MODE, 32'h0000_0001);
        rd_chk(MLC_REG_STATUS, 32'h0000_0037);
        chk(closed_loop, 1'b1);
        // Cascade: 100 through unity, velocity ceiling 400 mA, gives 40
        pos_set <= 16'sh0064;
        repeat (16) @(posedge clk_in);
        chk(pwm, 32'h0000_0028);
        wr(MLC_REG_MODE, 32'h0000_0002);
        rd_chk(MLC_REG_STATUS, 32'h0000_0035);
        wr(MLC_REG_SUBMODE, 32'h0000_0003);
        rd_chk(MLC_REG_STATUS, 32'h0000_0037);
        wr(MLC_REG_MODE, 32'h0000_0004);
        rd_chk(MLC_REG_STATUS, 32'h0000_0035);
        wr(MLC_REG_SUBMODE, 32'h0000_0021);
        rd_chk(MLC_REG_STATUS, 32'h0000_0031);
        // Zeroed selector is stored but never reaches the live set; status keeps the reset legacy bits
        wr(MLC_REG_LEGACY, 32'h0000_0000);
        rd_chk(MLC_REG_LEGACY, 32'h0000_0000);
        rd_chk(MLC_REG_STATUS, 32'h0000_0031);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence with a global hang limit
    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        reset_values();
        open_loop_limit();
        standstill_cut();
        stage_enables();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        final_report();
    end
endmodule
